// ---- design/hamc_pkg.sv ----
// Shared constants of the hot-alert and monitor configuration block.
// Assumes a 10 MHz mclk; every timing count below is derived from it.
package hamc_pkg;

	// ------------------------------------------------------------
	// Register offsets and power-on values
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_HOT_THRESH_A = 8'h36;
	localparam logic [7:0] OFF_PEAK_CUR_HOT = 8'h37;
	localparam logic [7:0] OFF_HOT_SRC_EN = 8'h38;
	localparam logic [7:0] OFF_DIS_HOT_CFG = 8'h39;
	localparam logic [7:0] OFF_MEAS_CH_EN = 8'h3a;
	localparam logic [7:0] OFF_MEAS_RUN = 8'h3b;
	localparam logic [7:0] RST_HOT_THRESH_A = 8'h65;
	localparam logic [7:0] RST_PEAK_CUR_HOT = 8'h4a;
	localparam logic [7:0] RST_HOT_SRC_EN = 8'ha0;
	localparam logic [7:0] RST_DIS_HOT_CFG = 8'h81;
	localparam logic [7:0] RST_MEAS_CH_EN = 8'h00;
	localparam logic [7:0] RST_MEAS_RUN = 8'h20;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ASSIST_LSB = 4;
	localparam int ALERT_LVL_LSB = 2;
	localparam int NORM_FILT_BIT = 1;
	localparam int LOW_REG_SEL_BIT = 0;
	localparam int SECOND_PCT_LSB = 3;
	localparam int CRIT_FILT_LSB = 1;
	localparam int REG_PCT_BIT = 0;
	localparam int DIS_LVL_LSB = 2;
	localparam int DIS_FILT_LSB = 0;
	localparam int REPEAT_BIT = 7;
	localparam int START_BIT = 6;

	// Alert source positions, shared by the enable register and the source vector.
	localparam int SRC_REG = 7;
	localparam int SRC_CRIT = 5;
	localparam int SRC_NORM = 4;
	localparam int SRC_DIS = 3;
	localparam int SRC_SYS = 2;

	// ------------------------------------------------------------
	// Analog scale values
	// ------------------------------------------------------------
	localparam logic [12:0] ASSIST_MULTI_BASE_MV = 13'd5900;
	localparam logic [12:0] ASSIST_SINGLE_BASE_MV = 13'd3100;
	localparam logic [12:0] ASSIST_STEP_MV = 13'd100;
	localparam logic [8:0] PCT_FINE_BASE = 9'd105;
	localparam logic [8:0] PCT_FINE_STEP = 9'd5;
	localparam logic [8:0] PCT_COARSE_BASE = 9'd250;
	localparam logic [8:0] PCT_COARSE_STEP = 9'd50;
	localparam logic [4:0] PCT_FINE_LAST = 5'h19;
	localparam logic [4:0] PCT_COARSE_FIRST = 5'h1a;
	localparam logic [4:0] PCT_COARSE_LAST = 5'h1e;
	localparam logic [6:0] REG_PCT_FULL = 7'd100;
	localparam logic [6:0] REG_PCT_80 = 7'd80;
	localparam logic [6:0] REG_PCT_90 = 7'd90;
	localparam logic [15:0] DIS_STEP_MA = 16'd512;
	localparam logic [15:0] DIS_OFFSET_MA = 16'd128;
	localparam logic [21:0] PCT_DIVISOR = 22'd100;

	// ------------------------------------------------------------
	// Filter and repeat times in ns, and cycle counts
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int CNT_W = 24;
	localparam int T_NORM_SHORT_NS = 1000000;
	localparam int T_NORM_LONG_NS = 50000000;
	localparam int T_CRIT_15US_NS = 15000;
	localparam int T_CRIT_100US_NS = 100000;
	localparam int T_CRIT_400US_NS = 400000;
	localparam int T_CRIT_800US_NS = 800000;
	localparam int T_DIS_1P6MS_NS = 1600000;
	localparam int T_DIS_100US_NS = 100000;
	localparam int T_DIS_6MS_NS = 6000000;
	localparam int T_DIS_12MS_NS = 12000000;
	localparam int T_REPEAT_NS = 1000000000;
	localparam int CYC_NORM_SHORT = (T_NORM_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_NORM_LONG = (T_NORM_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_CRIT_15US = (T_CRIT_15US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_CRIT_100US = (T_CRIT_100US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_CRIT_400US = (T_CRIT_400US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_CRIT_800US = (T_CRIT_800US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_DIS_1P6MS = (T_DIS_1P6MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_DIS_100US = (T_DIS_100US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_DIS_6MS = (T_DIS_6MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_DIS_12MS = (T_DIS_12MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_REPEAT = T_REPEAT_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_ADDR = 3'b001,
		BUS_PTR = 3'b010,
		BUS_WDATA = 3'b011,
		BUS_ACK = 3'b100,
		BUS_RDATA = 3'b101,
		BUS_RACK = 3'b110
	} hamc_bus_t;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b00,
		CONV_RUN = 2'b01,
		CONV_GAP = 2'b10
	} hamc_conv_t;

endpackage

// ---- design/hamc_deglitch.sv ----
// Persistence filter for one alert source condition.
// Assumes the condition input is synchronous to mclk.
`timescale 1ns/1ps

module hamc_deglitch (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic cond,
	input wire logic [hamc_pkg::CNT_W-1:0] limit,
	output logic filtered
);

	logic [hamc_pkg::CNT_W-1:0] count;

	// A drop of the condition restarts the wait, so only an unbroken run counts.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
		end else if (!cond) begin
			count <= '0;
		end else if (count < limit) begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			filtered <= 1'b0;
		end else begin
			filtered <= cond && (count >= limit - 1'b1);
		end
	end

endmodule

// ---- design/hamc_hot_alert_cfg.sv ----
// Hot-alert and monitor configuration registers behind an I2C target port.
// Assumes scl and sdaIn are already synchronous to mclk; the analog side
// supplies comparator results and measured values, also synchronous.
//
// Summary of operation
// R1: Multi-cell assist level: 5.9V plus 0.1V steps.
// R2: Single-cell assist level uses low three bits.
// R3: Two-bit alert level picks one of four voltages.
// R4: Normal-current filter: 1ms clear, 50ms set.
// R5: Regulation alert trips full or selected lower level.
// R6: Second limit code maps to percent steps.
// R7: Second limit scales programmed input current limit.
// R8: Critical-current filter: 15, 100, 400, 800us.
// R9: Lower regulation alert level 80% or 90%.
// R10: Per-source alert enables with documented defaults.
// R11: Battery and adapter removal enables, default off.
// R12: Discharge level 512mA steps plus 128mA offset.
// R13: Discharge level zero keeps alert triggered.
// R14: Discharge filter: 1.6ms, 100us, 6ms, 12ms.
// R15: Eight channel enables select monitor conversions.
// R16: Repeat bit selects one-shot or every 1s.
// R17: Host sets start; device clears after one-shot.
// R18: Host keeps reserved low control bits unchanged.
// R19: Alert low while enabled filtered source persists.
// R20: Power-on defaults; byte-wide I2C register access.
`timescale 1ns/1ps

module hamc_hot_alert_cfg #(
	parameter logic [6:0] DEV_ADDR = 7'h2a,
	parameter logic [23:0] NORM_SHORT_CYC = 24'(hamc_pkg::CYC_NORM_SHORT),
	parameter logic [23:0] NORM_LONG_CYC = 24'(hamc_pkg::CYC_NORM_LONG),
	parameter logic [23:0] CRIT_800US_CYC = 24'(hamc_pkg::CYC_CRIT_800US),
	parameter logic [23:0] DIS_1P6MS_CYC = 24'(hamc_pkg::CYC_DIS_1P6MS),
	parameter logic [23:0] DIS_6MS_CYC = 24'(hamc_pkg::CYC_DIS_6MS),
	parameter logic [23:0] DIS_12MS_CYC = 24'(hamc_pkg::CYC_DIS_12MS),
	parameter logic [23:0] REPEAT_CYC = 24'(hamc_pkg::CYC_REPEAT)
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic singleCell,
	input wire logic [12:0] inputCurrentLimitMa,
	input wire logic regTripFull,
	input wire logic regTripLower,
	input wire logic compTrip,
	input wire logic critCurrentTrip,
	input wire logic normCurrentTrip,
	input wire logic [15:0] dischargeCurrentMa,
	input wire logic [12:0] sysRailMv,
	input wire logic batteryRemoved,
	input wire logic adapterRemoved,
	input wire logic convDone,
	output logic hotAlertN,
	output logic [12:0] sysRailAssistMv,
	output logic [12:0] sysRailAlertMv,
	output logic [8:0] secondLimitPct,
	output logic [15:0] secondLimitMa,
	output logic [6:0] regAlertPct,
	output logic [15:0] dischargeAlertMa,
	output logic [7:0] measChannelEn,
	output logic convStart,
	output logic convBusy
);

	logic [7:0] hotThreshA;
	logic [7:0] peakCurHot;
	logic [7:0] hotSrcEn;
	logic [7:0] disHotCfg;
	logic [7:0] measRun;

	// ------------------------------------------------------------
	// I2C target
	// ------------------------------------------------------------
	hamc_pkg::hamc_bus_t busState;
	hamc_pkg::hamc_bus_t afterAck;
	logic sclQ;
	logic sdaQ;
	logic [3:0] bitCount;
	logic [7:0] shiftReg;
	logic [7:0] regPtr;
	logic hostNack;
	logic wrStrobe;
	logic [7:0] rdData;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	assign sclRise = scl && !sclQ;
	assign sclFall = !scl && sclQ;
	assign startSeen = scl && sclQ && sdaQ && !sdaIn;
	assign stopSeen = scl && sclQ && !sdaQ && sdaIn;
	assign sdaOut = 1'b0;
	assign sdaOe = (busState == hamc_pkg::BUS_ACK) ||
		((busState == hamc_pkg::BUS_RDATA) && !shiftReg[7]);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else begin
			sclQ <= scl;
			sdaQ <= sdaIn;
		end
	end

	// Unmapped offsets read as zero; writes to them are dropped.
	always_comb begin
		case (regPtr)
			hamc_pkg::OFF_HOT_THRESH_A: rdData = hotThreshA;
			hamc_pkg::OFF_PEAK_CUR_HOT: rdData = peakCurHot;
			hamc_pkg::OFF_HOT_SRC_EN: rdData = hotSrcEn;
			hamc_pkg::OFF_DIS_HOT_CFG: rdData = disHotCfg;
			hamc_pkg::OFF_MEAS_CH_EN: rdData = measChannelEn;
			hamc_pkg::OFF_MEAS_RUN: rdData = measRun;
			default: rdData = 8'h00;
		endcase
	end

	// One byte per register; the pointer advances after each data byte. [R20]
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			busState <= hamc_pkg::BUS_IDLE;
			afterAck <= hamc_pkg::BUS_IDLE;
			bitCount <= 4'h0;
			shiftReg <= 8'h00;
			regPtr <= 8'h00;
			hostNack <= 1'b0;
			wrStrobe <= 1'b0;
		end else begin
			wrStrobe <= 1'b0;
			if (startSeen) begin
				busState <= hamc_pkg::BUS_ADDR;
				bitCount <= 4'h0;
			end else if (stopSeen) begin
				busState <= hamc_pkg::BUS_IDLE;
			end else begin
				case (busState)
					hamc_pkg::BUS_ADDR, hamc_pkg::BUS_PTR, hamc_pkg::BUS_WDATA: begin
						if (sclRise) begin
							shiftReg <= {shiftReg[6:0], sdaIn};
							bitCount <= bitCount + 4'h1;
						end else if (sclFall && bitCount == 4'h8) begin
							bitCount <= 4'h0;
							busState <= hamc_pkg::BUS_ACK;
							if (busState == hamc_pkg::BUS_ADDR) begin
								if (shiftReg[7:1] != DEV_ADDR) begin
									busState <= hamc_pkg::BUS_IDLE;
								end
								afterAck <= shiftReg[0] ? hamc_pkg::BUS_RDATA : hamc_pkg::BUS_PTR;
							end else if (busState == hamc_pkg::BUS_PTR) begin
								regPtr <= shiftReg;
								afterAck <= hamc_pkg::BUS_WDATA;
							end else begin
								wrStrobe <= 1'b1;
								regPtr <= regPtr + 8'h01;
								afterAck <= hamc_pkg::BUS_WDATA;
							end
						end
					end
					hamc_pkg::BUS_ACK: begin
						if (sclFall) begin
							busState <= afterAck;
							if (afterAck == hamc_pkg::BUS_RDATA) begin
								shiftReg <= rdData;
								regPtr <= regPtr + 8'h01;
							end
						end
					end
					hamc_pkg::BUS_RDATA: begin
						if (sclFall) begin
							if (bitCount == 4'h7) begin
								bitCount <= 4'h0;
								busState <= hamc_pkg::BUS_RACK;
							end else begin
								shiftReg <= {shiftReg[6:0], 1'b1};
								bitCount <= bitCount + 4'h1;
							end
						end
					end
					hamc_pkg::BUS_RACK: begin
						if (sclRise) begin
							hostNack <= sdaIn;
						end else if (sclFall) begin
							if (hostNack) begin
								busState <= hamc_pkg::BUS_IDLE;
							end else begin
								busState <= hamc_pkg::BUS_RDATA;
								shiftReg <= rdData;
								regPtr <= regPtr + 8'h01;
							end
						end
					end
					default: busState <= hamc_pkg::BUS_IDLE;
				endcase
			end
		end
	end

	// The write lands one cycle after the byte, so its pointer and data are held here while the pointer steps at once.
	logic [7:0] wrPtr;
	logic [7:0] wrData;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wrPtr <= 8'h00;
			wrData <= 8'h00;
		end else if (busState == hamc_pkg::BUS_WDATA && sclFall && bitCount == 4'h8) begin
			wrPtr <= regPtr;
			wrData <= shiftReg;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic startClear;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hotThreshA <= hamc_pkg::RST_HOT_THRESH_A; // [R20]
			peakCurHot <= hamc_pkg::RST_PEAK_CUR_HOT;
			hotSrcEn <= hamc_pkg::RST_HOT_SRC_EN; // [R10] [R11]
			disHotCfg <= hamc_pkg::RST_DIS_HOT_CFG;
			measChannelEn <= hamc_pkg::RST_MEAS_CH_EN; // [R15]
		end else if (wrStrobe) begin
			case (wrPtr)
				hamc_pkg::OFF_HOT_THRESH_A: hotThreshA <= wrData;
				hamc_pkg::OFF_PEAK_CUR_HOT: peakCurHot <= wrData;
				hamc_pkg::OFF_HOT_SRC_EN: hotSrcEn <= wrData;
				hamc_pkg::OFF_DIS_HOT_CFG: disHotCfg <= wrData;
				hamc_pkg::OFF_MEAS_CH_EN: measChannelEn <= wrData;
				default: ;
			endcase
		end
	end

	// Reserved low bits are stored as written; the host is expected to keep them. [R18]
	// A host write in the clearing cycle wins, so a new start is never lost.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			measRun <= hamc_pkg::RST_MEAS_RUN;
		end else if (wrStrobe && wrPtr == hamc_pkg::OFF_MEAS_RUN) begin
			measRun <= wrData;
		end else if (startClear) begin
			measRun[hamc_pkg::START_BIT] <= 1'b0; // [R17]
		end
	end

	// ------------------------------------------------------------
	// Decoded levels for the analog side
	// ------------------------------------------------------------
	logic [3:0] assistCode;
	logic [1:0] alertCode;
	logic [4:0] pctCode;
	logic [5:0] disCode;
	logic [21:0] limitProduct;

	assign assistCode = hotThreshA[hamc_pkg::ASSIST_LSB +: 4];
	assign alertCode = hotThreshA[hamc_pkg::ALERT_LVL_LSB +: 2];
	assign pctCode = peakCurHot[hamc_pkg::SECOND_PCT_LSB +: 5];
	assign disCode = disHotCfg[hamc_pkg::DIS_LVL_LSB +: 6];
	assign limitProduct = 22'(inputCurrentLimitMa) * 22'(secondLimitPct);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sysRailAssistMv <= '0;
			sysRailAlertMv <= '0;
		end else begin
			if (singleCell) begin
				sysRailAssistMv <= hamc_pkg::ASSIST_SINGLE_BASE_MV +
					13'(assistCode[2:0]) * hamc_pkg::ASSIST_STEP_MV; // [R2]
			end else begin
				sysRailAssistMv <= hamc_pkg::ASSIST_MULTI_BASE_MV +
					13'(assistCode) * hamc_pkg::ASSIST_STEP_MV; // [R1]
			end
			case (alertCode) // [R3]
				2'b00: sysRailAlertMv <= singleCell ? 13'd3100 : 13'd5900;
				2'b01: sysRailAlertMv <= singleCell ? 13'd3300 : 13'd6200;
				2'b10: sysRailAlertMv <= singleCell ? 13'd3500 : 13'd6500;
				default: sysRailAlertMv <= singleCell ? 13'd3700 : 13'd6800;
			endcase
		end
	end

	// Codes 00000 and 11111 have no defined ratio and read out as zero percent.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			secondLimitPct <= '0;
			secondLimitMa <= '0;
			regAlertPct <= '0;
			dischargeAlertMa <= '0;
		end else begin
			if (pctCode != 5'h00 && pctCode <= hamc_pkg::PCT_FINE_LAST) begin
				secondLimitPct <= hamc_pkg::PCT_FINE_BASE +
					9'(pctCode) * hamc_pkg::PCT_FINE_STEP; // [R6]
			end else if (pctCode >= hamc_pkg::PCT_COARSE_FIRST &&
				pctCode <= hamc_pkg::PCT_COARSE_LAST) begin
				secondLimitPct <= hamc_pkg::PCT_COARSE_BASE +
					9'(pctCode - hamc_pkg::PCT_COARSE_FIRST) * hamc_pkg::PCT_COARSE_STEP;
			end else begin
				secondLimitPct <= '0;
			end
			secondLimitMa <= 16'(limitProduct / hamc_pkg::PCT_DIVISOR); // [R7]
			if (!hotThreshA[hamc_pkg::LOW_REG_SEL_BIT]) begin
				regAlertPct <= hamc_pkg::REG_PCT_FULL; // [R5]
			end else begin
				regAlertPct <= peakCurHot[hamc_pkg::REG_PCT_BIT] ?
					hamc_pkg::REG_PCT_90 : hamc_pkg::REG_PCT_80; // [R9]
			end
			dischargeAlertMa <= 16'(disCode) * hamc_pkg::DIS_STEP_MA +
				hamc_pkg::DIS_OFFSET_MA; // [R12]
		end
	end

	// ------------------------------------------------------------
	// Alert sources, filters and the alert pin
	// ------------------------------------------------------------
	logic [7:0] srcRaw;
	logic [7:0] srcFilt;
	logic [2:0] filtCond;
	logic [2:0] filtOut;
	logic [hamc_pkg::CNT_W-1:0] filtLimit [3];
	logic [hamc_pkg::CNT_W-1:0] critLimit;
	logic [hamc_pkg::CNT_W-1:0] disLimit;

	always_comb begin
		case (peakCurHot[hamc_pkg::CRIT_FILT_LSB +: 2]) // [R8]
			2'b00: critLimit = 24'(hamc_pkg::CYC_CRIT_15US);
			2'b01: critLimit = 24'(hamc_pkg::CYC_CRIT_100US);
			2'b10: critLimit = 24'(hamc_pkg::CYC_CRIT_400US);
			default: critLimit = CRIT_800US_CYC;
		endcase
		case (disHotCfg[hamc_pkg::DIS_FILT_LSB +: 2]) // [R14]
			2'b00: disLimit = DIS_1P6MS_CYC;
			2'b01: disLimit = 24'(hamc_pkg::CYC_DIS_100US);
			2'b10: disLimit = DIS_6MS_CYC;
			default: disLimit = DIS_12MS_CYC;
		endcase
	end

	assign filtLimit[0] = critLimit;
	assign filtLimit[1] = hotThreshA[hamc_pkg::NORM_FILT_BIT] ?
		NORM_LONG_CYC : NORM_SHORT_CYC; // [R4]
	assign filtLimit[2] = disLimit;
	assign filtCond[0] = critCurrentTrip;
	assign filtCond[1] = normCurrentTrip;
	// A zero level code forces the discharge source on. [R13]
	assign filtCond[2] = (disCode == 6'h00) || (dischargeCurrentMa > dischargeAlertMa);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_filt
			hamc_deglitch u_filt (
				.mclk(mclk),
				.rstn(rstn),
				.cond(filtCond[gi]),
				.limit(filtLimit[gi]),
				.filtered(filtOut[gi])
			);
		end
	endgenerate

	assign srcRaw = {regTripFull, compTrip, 3'b000, sysRailMv < sysRailAlertMv,
		batteryRemoved, adapterRemoved};

	always_comb begin
		srcFilt = srcRaw;
		srcFilt[hamc_pkg::SRC_REG] = hotThreshA[hamc_pkg::LOW_REG_SEL_BIT] ?
			regTripLower : regTripFull; // [R5]
		srcFilt[hamc_pkg::SRC_CRIT] = filtOut[0];
		srcFilt[hamc_pkg::SRC_NORM] = filtOut[1];
		srcFilt[hamc_pkg::SRC_DIS] = filtOut[2];
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hotAlertN <= 1'b1;
		end else begin
			hotAlertN <= !(|(srcFilt & hotSrcEn)); // [R10] [R11] [R19]
		end
	end

	// ------------------------------------------------------------
	// Monitor conversion sequencing
	// ------------------------------------------------------------
	hamc_pkg::hamc_conv_t convState;
	logic [hamc_pkg::CNT_W-1:0] periodCount;

	assign convBusy = (convState == hamc_pkg::CONV_RUN);

	// The repeat period runs from one conversion start to the next.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			convState <= hamc_pkg::CONV_IDLE;
			convStart <= 1'b0;
			startClear <= 1'b0;
			periodCount <= '0;
		end else begin
			convStart <= 1'b0;
			startClear <= 1'b0;
			if (convState != hamc_pkg::CONV_IDLE && periodCount < REPEAT_CYC) begin
				periodCount <= periodCount + 1'b1;
			end
			case (convState)
				hamc_pkg::CONV_IDLE: begin
					// The start bit still reads set while its clear is pending.
					if (measRun[hamc_pkg::START_BIT] && !startClear) begin // [R17]
						convStart <= 1'b1; // [R15]
						periodCount <= '0;
						convState <= hamc_pkg::CONV_RUN;
					end
				end
				hamc_pkg::CONV_RUN: begin
					if (convDone) begin
						if (measRun[hamc_pkg::REPEAT_BIT] && measRun[hamc_pkg::START_BIT]) begin
							convState <= hamc_pkg::CONV_GAP; // [R16]
						end else begin
							startClear <= 1'b1; // [R17]
							convState <= hamc_pkg::CONV_IDLE;
						end
					end
				end
				hamc_pkg::CONV_GAP: begin
					if (!measRun[hamc_pkg::START_BIT] || !measRun[hamc_pkg::REPEAT_BIT]) begin
						convState <= hamc_pkg::CONV_IDLE;
					end else if (periodCount >= REPEAT_CYC - 1'b1) begin
						convStart <= 1'b1; // [R16]
						periodCount <= '0;
						convState <= hamc_pkg::CONV_RUN;
					end
				end
				default: convState <= hamc_pkg::CONV_IDLE;
			endcase
		end
	end

endmodule

// ---- tb/hamc_host_model.sv ----
// I2C host model for the configuration block's target port.
// Assumes an open-drain SDA with a pull-up and a running mclk.
`timescale 1ns/1ps

module hamc_host_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	input wire logic mclk,
	input wire logic sdaOe,
	output logic scl,
	output logic sdaIn
);
	logic sdaR;
	initial begin
		scl = 1'b1;
		sdaR = 1'b1;
	end
	// A released line reads high through the pull-up.
	assign sdaIn = sdaOe ? 1'b0 : sdaR;
	task automatic hp;
		repeat (4) @(posedge mclk);
	endtask
	task automatic bitx(input logic b, output logic q);
		sdaR <= b;
		hp();
		scl <= 1'b1;
		hp();
		q = sdaIn;
		scl <= 1'b0;
		hp();
	endtask
	task automatic sta;
		sdaR <= 1'b1;
		hp();
		scl <= 1'b1;
		hp();
		sdaR <= 1'b0;
		hp();
		scl <= 1'b0;
		hp();
	endtask
	task automatic xfer(input logic [7:0] d, input logic l, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(l, a);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic a);
		logic [7:0] q;
		logic a0, a1;
		sta();
		xfer({ADDR, 1'b0}, 1'b1, q, a0);
		xfer(p, 1'b1, q, a1);
		xfer(d, 1'b1, q, a);
		a = a | a0 | a1;
		sdaR <= 1'b0;
		hp();
		scl <= 1'b1;
		hp();
		sdaR <= 1'b1;
		hp();
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic a);
		logic [7:0] q;
		logic a0, a1, a2;
		sta();
		xfer({ADDR, 1'b0}, 1'b1, q, a0);
		xfer(p, 1'b1, q, a1);
		sta();
		xfer({ADDR, 1'b1}, 1'b1, q, a2);
		xfer(8'hff, 1'b1, d, a);
		a = a0 | a1 | a2;
		sdaR <= 1'b0;
		hp();
		scl <= 1'b1;
		hp();
		sdaR <= 1'b1;
		hp();
	endtask
endmodule

// ---- tb/hamc_checker.sv ----
// Checker of decoded levels and the conversion handshake.
// Assumes it is bound to the configuration block.
`timescale 1ns/1ps

module hamc_checker (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic singleCell,
	input wire logic convStart,
	input wire logic convBusy,
	input wire logic [12:0] sysRailAssistMv,
	input wire logic [12:0] sysRailAlertMv,
	input wire logic [8:0] secondLimitPct,
	input wire logic [6:0] regAlertPct,
	input wire logic [15:0] dischargeAlertMa
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	AST_START_BUSY: assert property (convStart |=> convBusy)
		else $error("busy missing after start");
	AST_START_PULSE: assert property (convStart |=> !convStart)
		else $error("start not a pulse");
	AST_MULTI_ASSIST: assert property ($past(rstn) && !singleCell && !$past(singleCell) |->
		sysRailAssistMv inside {[5900:7400]} && sysRailAssistMv % 100 == 0)
		else $error("bad multi-cell assist level");
	AST_SINGLE_ASSIST: assert property ($past(rstn) && singleCell && $past(singleCell) |->
		sysRailAssistMv inside {[3100:3800]} && sysRailAssistMv % 100 == 0)
		else $error("bad single-cell assist level");
	AST_ALERT_LEVEL: assert property ($past(rstn) |->
		sysRailAlertMv inside {5900, 6200, 6500, 6800, 3100, 3300, 3500, 3700})
		else $error("bad alert level");
	AST_PCT_CODES: assert property ($past(rstn) |->
		secondLimitPct inside {0, [110:230], 250, 300, 350, 400, 450} && secondLimitPct % 5 == 0)
		else $error("bad second limit percent");
	AST_REG_PCT: assert property ($past(rstn) |-> regAlertPct inside {80, 90, 100})
		else $error("bad regulation percent");
	AST_DIS_STEP: assert property ($past(rstn) |-> dischargeAlertMa % 512 == 128)
		else $error("bad discharge level");
endmodule

bind hamc_hot_alert_cfg hamc_checker hamc_checker_i (.mclk, .rstn, .singleCell, .convStart,
	.convBusy, .sysRailAssistMv, .sysRailAlertMv, .secondLimitPct, .regAlertPct,
	.dischargeAlertMa);

// ---- tb/hamc_hot_alert_cfg_test.sv ----
// Self-checking bench for the hot-alert and monitor configuration block.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps

module hamc_hot_alert_cfg_test;
	logic mclk = 1'b0, rstn = 1'b0, singleCell = 1'b0, convDone = 1'b0, sysLow, a;
	logic scl, sdaIn, sdaOut, sdaOe, hotAlertN, convStart, convBusy;
	logic regTripFull, regTripLower, compTrip, batteryRemoved, adapterRemoved;
	logic critTrip = 1'b0, normTrip = 1'b0;
	logic [5:0] trip = 6'h00;
	logic [12:0] sysRailMv, sysRailAssistMv, sysRailAlertMv;
	logic [8:0] secondLimitPct;
	logic [15:0] secondLimitMa, dischargeAlertMa;
	logic [6:0] regAlertPct;
	logic [7:0] measChannelEn, q;
	int n_fail = 0, comparisons = 0, cyc = 0, nStart = 0, s;
	logic [23:0] rows [11] = '{24'h360065, 24'h37004a, 24'h3800a0, 24'h390081, 24'h3a0000,
		24'h3b0020, 24'h36f5f5, 24'h3aa5a5, 24'h3ba0a0, 24'h3b2020, 24'h405a00};
	int lim [3] = '{hamc_pkg::CYC_CRIT_15US, 60, 300};
	assign {sysLow, regTripFull, regTripLower, compTrip, batteryRemoved, adapterRemoved} = trip;
	assign sysRailMv = sysLow ? 13'd6000 : 13'd7000;
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		convDone <= convStart;
		nStart <= nStart + int'(convStart);
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	hamc_host_model hamc_host_model_i (.mclk, .sdaOe, .scl, .sdaIn);
	hamc_hot_alert_cfg #(.REPEAT_CYC(24'd200), .NORM_SHORT_CYC(24'd60),
		.NORM_LONG_CYC(24'd300)) hamc_hot_alert_cfg_i (.mclk, .rstn, .scl,
		.sdaIn, .sdaOut, .sdaOe, .singleCell, .inputCurrentLimitMa(13'd2000), .regTripFull,
		.regTripLower, .compTrip, .critCurrentTrip(critTrip), .normCurrentTrip(normTrip),
		.dischargeCurrentMa(16'd0), .sysRailMv, .batteryRemoved, .adapterRemoved, .convDone,
		.hotAlertN, .sysRailAssistMv, .sysRailAlertMv, .secondLimitPct, .secondLimitMa,
		.regAlertPct, .dischargeAlertMa, .measChannelEn, .convStart, .convBusy);
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (!ok) begin
			n_fail++;
			$display("Error %0t: %s", $time, m);
		end
	endtask
	task automatic w(input logic [7:0] p, input logic [7:0] d);
		hamc_host_model_i.wr(p, d, a);
		chk(a === 1'b0, "write not acknowledged");
	endtask
	task automatic r(input logic [7:0] p);
		hamc_host_model_i.rd(p, q, a);
		chk(a === 1'b0, "read not acknowledged");
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(sysRailAssistMv === 13'd6500 && sysRailAlertMv === 13'd6200, "volt levels");
		chk(secondLimitPct === 9'd150 && secondLimitMa === 16'd3000, "second limit");
		chk(regAlertPct === 7'd80 && dischargeAlertMa === 16'd16512, "alert levels");
		chk(measChannelEn === 8'h00 && hotAlertN === 1'b1 && sdaOut === 1'b0, "reset outputs");
		for (int i = 0; i < 11; i++) begin
			if (i > 5)
				w(rows[i][23:16], rows[i][15:8]);
			r(rows[i][23:16]);
			chk(q === rows[i][7:0], "register readback");
		end
		chk(sysRailAssistMv === 13'd7400 && measChannelEn === 8'ha5, "top code");
		singleCell <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(sysRailAssistMv === 13'd3800 && sysRailAlertMv === 13'd3300, "one cell");
		singleCell <= 1'b0;
		// Full-level trip must stay quiet while the lower level is selected.
		w(8'h38, 8'hc7);
		for (int i = 0; i < 6; i++) begin
			trip <= 6'(1 << i);
			repeat (3) @(posedge mclk);
			chk(hotAlertN === (i == 4), "alert source");
			trip <= 6'h00;
			repeat (3) @(posedge mclk);
			chk(hotAlertN === 1'b1, "alert release");
		end
		w(8'h39, 8'h01);
		w(8'h38, 8'h08);
		repeat (1100) @(posedge mclk);
		chk(hotAlertN === 1'b0 && dischargeAlertMa === 16'd128, "discharge zero");
		w(8'h38, 8'h00);
		w(8'h37, 8'h48);
		w(8'h38, 8'h30);
		for (int i = 0; i < 3; i++) begin
			if (i == 2)
				w(8'h36, 8'hf7);
			{critTrip, normTrip} <= (i == 0) ? 2'b10 : 2'b01;
			repeat (lim[i] - 10) @(posedge mclk);
			chk(hotAlertN === 1'b1, "alert before filter time");
			repeat (20) @(posedge mclk);
			chk(hotAlertN === 1'b0, "no alert after filter time");
			{critTrip, normTrip} <= 2'b00;
			repeat (3) @(posedge mclk);
		end
		s = nStart;
		w(8'h3b, 8'h60);
		repeat (20) @(posedge mclk);
		r(8'h3b);
		chk(q === 8'h20 && nStart == s + 1, "one-shot start");
		s = nStart;
		w(8'h3b, 8'he0);
		repeat (420) @(posedge mclk);
		chk(nStart == s + 3, "repeat period");
		w(8'h3b, 8'h20);
		wrap_up();
	end
endmodule
